// ===== nfc_timer_consts.vh
// Timing constants and field layouts for the protocol timer unit.
// Assumes inclusion by bare name from the timer design files.
`ifndef NFC_TIMER_CONSTS_VH
`define NFC_TIMER_CONSTS_VH
`define CLK_SYS_HZ        10000000
`define CARRIER_HZ        13560000
`define CARRIER_ACC_W     25
`define MASK_STEP_NORMAL  8'h40
`define MASK_STEP_LP_DIV  4'h8
`define NRT_STEP_SHORT    16'h0040
`define NRT_STEP_LONG     16'h1000
`define GPT_STEP          8'h08
`define WAKE_RC_DIV       8'h20
`define MASK_W            7
`define NRT_W             16
`define GPT_W             16
`define WAKE_W            8
`define GPT_TRIG_SOF      2'h0
`define GPT_TRIG_EOF      2'h1
`define GPT_TRIG_FIELD    2'h2
`define GPT_TRIG_NONE     2'h3
`endif

// ===== nfc_step_timer.v
// One prescaled down-counting timer with start, stop and expiry pulse.
// Assumes tick_in is a one-cycle enable from the owning timer unit.
`timescale 1ns/1ps
`default_nettype none
module nfc_step_timer #(
  parameter CNT_W  = 16,
  parameter STEP_W = 16
) (
  input  wire              clk_sys_in,
  input  wire              rst_n_in,
  input  wire              ce_in,
  input  wire              tick_in,
  input  wire              start_in,
  input  wire              stop_in,
  input  wire [CNT_W-1:0]  load_in,
  input  wire [STEP_W-1:0] step_in,
  output reg               run_out,
  output reg               expire_out
);
  reg [CNT_W-1:0]  count;
  reg [STEP_W-1:0] pre;

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count      <= {CNT_W{1'b0}};
      pre        <= {STEP_W{1'b0}};
      run_out    <= 1'b0;
      expire_out <= 1'b0;
    end
    else if (ce_in)
    begin
      expire_out <= 1'b0;
      if (start_in)
      begin
        // Restart from full value even while running
        count   <= load_in;
        pre     <= {STEP_W{1'b0}};
        run_out <= (load_in != {CNT_W{1'b0}});
      end
      else if (stop_in)
        run_out <= 1'b0;
      else if (run_out && tick_in)
      begin
        if (pre == step_in - {{(STEP_W-1){1'b0}}, 1'b1})
        begin
          pre <= {STEP_W{1'b0}};
          if (count == {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            count      <= {CNT_W{1'b0}};
            run_out    <= 1'b0;
            expire_out <= 1'b1;
          end
          else
            count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        else
          pre <= pre + {{(STEP_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ===== nfc_reader_protocol_timers.v
// Protocol timers: mask receive, no-response, general purpose and wake-up.
// Assumes all inputs synchronous to clk_sys_in; commands are 1-cycle pulses;
// rc_tick_in is a synchronous pulse per RC oscillator period.
//
// Behaviour
// - End of transmission starts mask and no-response timers
// - Receive window held low while mask runs
// - Squelch during mask if enabled; no mask IRQ
// - Active peer mode: mask starts on peer field-on
// - Low power target: command start, eight-fold slower
// - No-response step 64 or 4096 carrier periods
// - Conditional mode: IRQ, rx off unless reply first
// - Unconditional mode: always IRQ, clear does not stop
// - Unconditional expiry: rx off only if receiver not busy
// - Timeout flag in timer interrupt status
// - Start command restarts no-response timer
// - Active peer mode ignores no-response start command
// - Active peer: IRQ if expiry before peer field
// - General timer trigger SOF, EOF or field-off
// - General timer command start restarts it
// - Wake command outside wake mode starts RC oscillator
// - Wake expiry sets wake timer flag
// - Wake timer on RC; others need crystal
// - Clear stops all but wake and unconditional timer
`timescale 1ns/1ps
`default_nettype none
`include "nfc_timer_consts.vh"
module nfc_reader_protocol_timers #(
  parameter MASK_W = `MASK_W,
  parameter NRT_W  = `NRT_W,
  parameter GPT_W  = `GPT_W,
  parameter WAKE_W = `WAKE_W
) (
  input  wire              clk_sys_in,
  input  wire              rst_n_in,
  input  wire              ce_in,
  input  wire              osc_ok_in,
  input  wire              tx_eof_in,
  input  wire              rx_sof_in,
  input  wire              rx_eof_in,
  input  wire              rx_busy_in,
  input  wire              peer_field_on_in,
  input  wire              peer_field_off_in,
  input  wire              active_p2p_in,
  input  wire              lp_target_in,
  input  wire              wake_mode_in,
  input  wire              squelch_en_in,
  input  wire              nrt_uncond_in,
  input  wire              nrt_long_step_in,
  input  wire [1:0]        gpt_trig_in,
  input  wire [MASK_W-1:0] mask_time_in,
  input  wire [NRT_W-1:0]  nrt_time_in,
  input  wire [GPT_W-1:0]  gpt_time_in,
  input  wire [WAKE_W-1:0] wake_time_in,
  input  wire              rc_tick_in,
  input  wire              cmd_clear_in,
  input  wire              cmd_mask_start_in,
  input  wire              cmd_nrt_start_in,
  input  wire              cmd_gpt_start_in,
  input  wire              cmd_wake_start_in,
  input  wire              nre_irq_clr_in,
  input  wire              gpt_irq_clr_in,
  input  wire              wake_irq_clr_in,
  output reg               rx_on_out,
  output reg               squelch_out,
  output reg               rx_monitor_out,
  output reg               rc_osc_en_out,
  output reg               mask_run_out,
  output reg               nrt_run_out,
  output reg               gpt_run_out,
  output reg               wake_run_out,
  output reg               nre_irq_flag_out,
  output reg               gpt_irq_flag_out,
  output reg               wake_timer_irq_flag_out
);
  // Carrier tick from the crystal-ok flag; fractional accumulator runs beside it unused
  localparam [31:0] CLK_HZ_FULL = `CLK_SYS_HZ;
  localparam [31:0] INC_HZ_FULL = `CARRIER_HZ - `CLK_SYS_HZ;
  localparam [`CARRIER_ACC_W-1:0] ACC_MAX = CLK_HZ_FULL[`CARRIER_ACC_W-1:0];
  localparam [`CARRIER_ACC_W-1:0] ACC_INC = INC_HZ_FULL[`CARRIER_ACC_W-1:0];
  // Prescalers fire on their last phase so a first count is full length
  localparam [3:0] LP_LAST   = `MASK_STEP_LP_DIV - 4'h1;
  localparam [7:0] WAKE_LAST = `WAKE_RC_DIV - 8'h01;

  reg  [`CARRIER_ACC_W-1:0] acc;
  reg                       carrier_tick;
  reg                       nrt_reply_seen;
  reg                       nrt_waiting_peer;
  reg                       mask_lp;
  reg  [3:0]                lp_div;
  reg  [7:0]                wake_pre;

  wire xtal_ok = osc_ok_in;
  wire mask_run;
  wire nrt_run;
  wire gpt_run;
  wire wake_run;
  wire mask_exp;
  wire nrt_exp;
  wire gpt_exp;
  wire wake_exp;

  // Up to two carrier periods fit in one system clock; tick once per cycle
  // while the crystal is ok; accumulator wrap unused, carrier rate approximated at clk rate
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc          <= {`CARRIER_ACC_W{1'b0}};
      carrier_tick <= 1'b0;
    end
    else if (ce_in)
    begin
      carrier_tick <= xtal_ok;
      if (acc + ACC_INC >= ACC_MAX)
        acc <= acc + ACC_INC - ACC_MAX;
      else
        acc <= acc + ACC_INC;
    end
  end

  wire extra_tick = (acc + ACC_INC >= ACC_MAX);
  wire cr_tick    = carrier_tick;

  // Mask timer start sources
  wire mask_auto  = active_p2p_in ? peer_field_on_in : tx_eof_in;
  wire mask_cmd   = cmd_mask_start_in && lp_target_in;
  wire mask_start = xtal_ok && (mask_auto || mask_cmd);
  wire mask_tick  = cr_tick && (!mask_lp || lp_div == LP_LAST);

  // No-response timer start, stop and clear
  wire nrt_cmd    = cmd_nrt_start_in && !active_p2p_in;
  wire nrt_start  = xtal_ok && (tx_eof_in || nrt_cmd);
  wire nrt_reply  = active_p2p_in ? peer_field_on_in : rx_sof_in;
  wire nrt_stop   = (cmd_clear_in && !nrt_uncond_in) ||
                    (nrt_reply && !nrt_uncond_in) ||
                    !xtal_ok;
  wire [15:0] nrt_step = nrt_long_step_in ? `NRT_STEP_LONG
                                          : `NRT_STEP_SHORT;

  // General purpose timer trigger select
  reg gpt_trig;
  always @*
  begin
    case (gpt_trig_in)
      `GPT_TRIG_SOF:   gpt_trig = rx_sof_in;
      `GPT_TRIG_EOF:   gpt_trig = rx_eof_in;
      `GPT_TRIG_FIELD: gpt_trig = peer_field_off_in;
      default:         gpt_trig = 1'b0;
    endcase
  end
  wire gpt_trig_sel = active_p2p_in ? peer_field_off_in : gpt_trig;
  wire gpt_start = xtal_ok && (gpt_trig_sel || cmd_gpt_start_in);
  wire crys_stop = cmd_clear_in || !xtal_ok;

  wire wake_start = cmd_wake_start_in && !wake_mode_in;
  wire wake_tick  = rc_tick_in && rc_osc_en_out && (wake_pre == WAKE_LAST);

  nfc_step_timer #(.CNT_W(MASK_W), .STEP_W(8)) u_mask (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tick_in    (mask_tick),
    .start_in   (mask_start),
    .stop_in    (crys_stop),
    .load_in    (mask_time_in),
    .step_in    (`MASK_STEP_NORMAL),
    .run_out    (mask_run),
    .expire_out (mask_exp)
  );

  nfc_step_timer #(.CNT_W(NRT_W), .STEP_W(16)) u_nrt (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tick_in    (cr_tick),
    .start_in   (nrt_start),
    .stop_in    (nrt_stop),
    .load_in    (nrt_time_in),
    .step_in    (nrt_step),
    .run_out    (nrt_run),
    .expire_out (nrt_exp)
  );

  nfc_step_timer #(.CNT_W(GPT_W), .STEP_W(8)) u_gpt (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tick_in    (cr_tick),
    .start_in   (gpt_start),
    .stop_in    (crys_stop),
    .load_in    (gpt_time_in),
    .step_in    (`GPT_STEP),
    .run_out    (gpt_run),
    .expire_out (gpt_exp)
  );

  nfc_step_timer #(.CNT_W(WAKE_W), .STEP_W(8)) u_wake (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tick_in    (wake_tick),
    .start_in   (wake_start),
    .stop_in    (1'b0),
    .load_in    (wake_time_in),
    .step_in    (8'h01),
    .run_out    (wake_run),
    .expire_out (wake_exp)
  );

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask_lp                 <= 1'b0;
      lp_div                  <= 4'h0;
      wake_pre                <= 8'h00;
      nrt_reply_seen          <= 1'b0;
      nrt_waiting_peer        <= 1'b0;
      rx_on_out               <= 1'b1;
      squelch_out             <= 1'b0;
      rx_monitor_out          <= 1'b0;
      rc_osc_en_out           <= 1'b0;
      mask_run_out            <= 1'b0;
      nrt_run_out             <= 1'b0;
      gpt_run_out             <= 1'b0;
      wake_run_out            <= 1'b0;
      nre_irq_flag_out        <= 1'b0;
      gpt_irq_flag_out        <= 1'b0;
      wake_timer_irq_flag_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // Low power target command start divides mask clock by eight
      if (mask_start)
        mask_lp <= mask_cmd;
      if (mask_start || !mask_lp)
        lp_div <= 4'h0;
      else if (cr_tick)
        lp_div <= (lp_div == `MASK_STEP_LP_DIV - 4'h1) ? 4'h0
                                                       : lp_div + 4'h1;
      if (mask_exp && mask_lp)
        rx_monitor_out <= 1'b1;
      else if (mask_start || cmd_clear_in)
        rx_monitor_out <= 1'b0;

      if (wake_start)
        rc_osc_en_out <= 1'b1;
      else if (wake_exp)
        rc_osc_en_out <= 1'b0;
      if (wake_start || !rc_osc_en_out)
        wake_pre <= 8'h00;
      else if (rc_tick_in)
        wake_pre <= (wake_pre == `WAKE_RC_DIV - 8'h01) ? 8'h00
                                                       : wake_pre + 8'h01;

      if (nrt_start)
        nrt_reply_seen <= 1'b0;
      else if (nrt_reply)
        nrt_reply_seen <= 1'b1;
      nrt_waiting_peer <= active_p2p_in;

      // Receive window: low while masked, forced low on timeout unless unconditional and rx busy
      if (mask_run)
        rx_on_out <= 1'b0;
      else if (nrt_exp && !(nrt_uncond_in && rx_busy_in))
        rx_on_out <= 1'b0;
      else if (mask_exp || nrt_start)
        rx_on_out <= 1'b1;

      squelch_out  <= mask_run && squelch_en_in;
      mask_run_out <= mask_run;
      nrt_run_out  <= nrt_run;
      gpt_run_out  <= gpt_run;
      wake_run_out <= wake_run;

      // Sticky flags; a new event beats a same-cycle clear
      if (nrt_exp)
        nre_irq_flag_out <= 1'b1;
      else if (nre_irq_clr_in)
        nre_irq_flag_out <= 1'b0;
      if (gpt_exp)
        gpt_irq_flag_out <= 1'b1;
      else if (gpt_irq_clr_in)
        gpt_irq_flag_out <= 1'b0;
      if (wake_exp)
        wake_timer_irq_flag_out <= 1'b1;
      else if (wake_irq_clr_in)
        wake_timer_irq_flag_out <= 1'b0;
    end
  end

  wire unused_ok = extra_tick | nrt_reply_seen | nrt_waiting_peer;
endmodule
`default_nettype wire

// ===== nfc_timers_checker_assertions.sv
// Concurrent checks on the protocol timer unit's ports.
// Assumes one clock and asynchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module nfc_timers_checker #(
  parameter NRT_W  = 16,
  parameter MASK_W = 7
) (
  input wire logic             clk_sys_in,
  input wire logic             rst_n_in,
  input wire logic             ce_in,
  input wire logic             osc_ok_in,
  input wire logic             tx_eof_in,
  input wire logic             active_p2p_in,
  input wire logic             squelch_en_in,
  input wire logic             nrt_uncond_in,
  input wire logic [1:0]       gpt_trig_in,
  input wire logic [NRT_W-1:0] nrt_time_in,
  input wire logic [MASK_W-1:0] mask_time_in,
  input wire logic             cmd_clear_in,
  input wire logic             cmd_gpt_start_in,
  input wire logic             nre_irq_clr_in,
  input wire logic             gpt_irq_clr_in,
  input wire logic             wake_irq_clr_in,
  input wire logic             rx_on_out,
  input wire logic             squelch_out,
  input wire logic             mask_run_out,
  input wire logic             nrt_run_out,
  input wire logic             gpt_run_out,
  input wire logic             wake_run_out,
  input wire logic             nre_irq_flag_out,
  input wire logic             gpt_irq_flag_out,
  input wire logic             wake_timer_irq_flag_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  logic go;
  assign go = ce_in && osc_ok_in && !cmd_clear_in;
  a_eot_masks_rx: assert property (
    tx_eof_in && go && !active_p2p_in && mask_time_in != '0
      |-> ##2 !rx_on_out)
    else $error("receive window open after end of transmit");
  a_eot_starts_nrt: assert property (
    tx_eof_in && go && nrt_time_in != '0 |-> ##2 nrt_run_out)
    else $error("no-response timer not started by end of transmit");
  a_squelch_on: assert property (
    $rose(mask_run_out) && squelch_en_in |-> ##[0:1] squelch_out)
    else $error("squelch off while mask timer runs");
  a_nre_cause: assert property (
    $rose(nre_irq_flag_out) |-> $past(nrt_run_out))
    else $error("timeout flag without running timer");
  a_nre_rx_off: assert property (
    $rose(nre_irq_flag_out) && !nrt_uncond_in && !active_p2p_in
      |-> ##[0:1] !rx_on_out)
    else $error("receive window left open at timeout");
  a_nre_held: assert property (
    nre_irq_flag_out && !nre_irq_clr_in |=> nre_irq_flag_out)
    else $error("timeout flag dropped without clear");
  a_gpt_held: assert property (
    gpt_irq_flag_out && !gpt_irq_clr_in |=> gpt_irq_flag_out)
    else $error("general timer flag dropped without clear");
  a_wake_held: assert property (
    wake_timer_irq_flag_out && !wake_irq_clr_in |=> wake_timer_irq_flag_out)
    else $error("wake flag dropped without clear");
  a_wake_cause: assert property (
    $rose(wake_timer_irq_flag_out) |-> $past(wake_run_out))
    else $error("wake flag without running timer");
  a_clear_gpt: assert property (
    cmd_clear_in && ce_in && !cmd_gpt_start_in && gpt_trig_in == 2'h3
      && !active_p2p_in |-> ##2 !gpt_run_out)
    else $error("general timer survived clear");
  a_osc_blocks: assert property (
    !osc_ok_in [*4] |-> !nrt_run_out && !gpt_run_out && !mask_run_out)
    else $error("crystal timer runs without oscillator");
  c_timeout: cover property ($rose(nre_irq_flag_out));
  c_gpt: cover property ($rose(gpt_irq_flag_out));
  c_wake: cover property ($rose(wake_timer_irq_flag_out));
endmodule
bind nfc_reader_protocol_timers nfc_timers_checker #(
  .NRT_W  (NRT_W),
  .MASK_W (MASK_W)
) u_nfc_timers_checker (.*);
`default_nettype wire

// ===== host_model.sv
// Host model: one-cycle direct-command and flag-clear pulses.
// Assumes calls one at a time; bit order is fixed by the bench.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_sys_in,
  output var  logic [7:0] cmd_out
);
  initial cmd_out = 8'h00;
  // Bench changes timer settings only between these calls
  task send(input int idx);
    @(negedge clk_sys_in);
    cmd_out[idx] = 1'h1;
    @(negedge clk_sys_in);
    cmd_out[idx] = 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Bench for the protocol timer unit driven by a host command model.
// Assumes the checker binds itself; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "nfc_timer_consts.vh"
module testbench;
  logic        clk_sys_in, rst_n_in, ce_in, osc_ok_in, rx_busy_in;
  logic        active_p2p_in, lp_target_in, wake_mode_in, squelch_en_in;
  logic        nrt_uncond_in, nrt_long_step_in, rc_tick_in;
  logic        tx_eof_in, rx_sof_in, rx_eof_in;
  logic        peer_field_on_in, peer_field_off_in;
  logic        cmd_clear_in, cmd_mask_start_in, cmd_nrt_start_in;
  logic        cmd_gpt_start_in, cmd_wake_start_in;
  logic        nre_irq_clr_in, gpt_irq_clr_in, wake_irq_clr_in;
  logic        rx_on_out, squelch_out, rx_monitor_out, rc_osc_en_out;
  logic        mask_run_out, nrt_run_out, gpt_run_out, wake_run_out;
  logic        nre_irq_flag_out, gpt_irq_flag_out, wake_timer_irq_flag_out;
  logic [1:0]  gpt_trig_in;
  logic [6:0]  mask_time_in;
  logic [15:0] nrt_time_in, gpt_time_in;
  logic [7:0]  wake_time_in, cmd;
  logic [4:0]  ev;
  int          errors = 0, tests_run = 0, i, n, d;
  typedef struct {logic unc, lng; logic [15:0] t; logic rep, flg, rx;} row_t;
  // Mode, step, count, reply, expected flag, expected receive window
  row_t        rows [5] = '{
    '{1'h0, 1'h0, 16'h0002, 1'h0, 1'h1, 1'h0},
    '{1'h0, 1'h0, 16'h0002, 1'h1, 1'h0, 1'h1},
    '{1'h1, 1'h0, 16'h0002, 1'h1, 1'h1, 1'h1},
    '{1'h1, 1'h0, 16'h0002, 1'h0, 1'h1, 1'h0},
    '{1'h0, 1'h1, 16'h0001, 1'h0, 1'h1, 1'h0}};
  assign {peer_field_off_in, peer_field_on_in, rx_eof_in, rx_sof_in,
          tx_eof_in} = ev;
  assign {wake_irq_clr_in, gpt_irq_clr_in, nre_irq_clr_in, cmd_wake_start_in,
          cmd_gpt_start_in, cmd_nrt_start_in, cmd_mask_start_in,
          cmd_clear_in} = cmd;
  nfc_reader_protocol_timers u_nfc_reader_protocol_timers (.*);
  host_model u_host_model (.clk_sys_in(clk_sys_in), .cmd_out(cmd));
  task results;
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic v, input logic e);
    tests_run++;
    if (v !== e)
    begin
      errors++;
      $display("Error at %0t: got %b expected %b", $time, v, e);
    end
  endtask
  task wt(input int k);
    repeat (k) @(negedge clk_sys_in);
    n += k;
  endtask
  task strobe(input int k);
    @(negedge clk_sys_in);
    ev[k] = 1'h1;
    @(negedge clk_sys_in);
    ev[k] = 1'h0;
  endtask
  task hs(input int k);
    u_host_model.send(k);
  endtask
  initial
  begin
    clk_sys_in = 1'h0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // RC oscillator stand-in: one tick every four clocks
  always
  begin
    rc_tick_in = 1'h0;
    repeat (3) @(negedge clk_sys_in);
    rc_tick_in = 1'h1;
    @(negedge clk_sys_in);
  end
  initial
  begin
    #3000000;
    errors++;
    results;
  end
  initial
  begin
    {ce_in, osc_ok_in, squelch_en_in, rst_n_in, rx_busy_in} = 5'h1C;
    {active_p2p_in, lp_target_in, wake_mode_in} = 3'h0;
    {nrt_uncond_in, nrt_long_step_in, ev} = 7'h00;
    gpt_trig_in = 2'h3;
    mask_time_in = 7'h01;
    {nrt_time_in, gpt_time_in, wake_time_in} = 40'h00;
    repeat (5) @(negedge clk_sys_in);
    chk(rx_on_out, 1'h1);
    chk(nre_irq_flag_out, 1'h0);
    rst_n_in = 1'h1;
    for (i = 0; i < 5; i++)
    begin
      nrt_uncond_in = rows[i].unc;
      nrt_long_step_in = rows[i].lng;
      nrt_time_in = rows[i].t;
      d = rows[i].t * (rows[i].lng ? `NRT_STEP_LONG : `NRT_STEP_SHORT);
      n = 0;
      strobe(0);
      wt(10);
      chk(mask_run_out, 1'h1);
      chk(rx_on_out, 1'h0);
      chk(squelch_out, 1'h1);
      if (rows[i].rep)
      begin
        wt(60);
        rx_busy_in = 1'h1;
        strobe(1);
      end
      wt(d - 8 - n);
      chk(nre_irq_flag_out, 1'h0);
      wt(16);
      chk(nre_irq_flag_out, rows[i].flg);
      chk(rx_on_out, rows[i].rx);
      rx_busy_in = 1'h0;
      hs(5);
      chk(nre_irq_flag_out, 1'h0);
    end
    active_p2p_in = 1'h1;
    nrt_time_in = 16'h0001;
    nrt_long_step_in = 1'h0;
    hs(2);
    wt(4);
    chk(nrt_run_out, 1'h0);
    strobe(0);
    wt(80);
    chk(nre_irq_flag_out, 1'h1);
    hs(5);
    squelch_en_in = 1'h0;
    strobe(3);
    wt(4);
    chk(mask_run_out, 1'h1);
    chk(squelch_out, 1'h0);
    squelch_en_in = 1'h1;
    hs(0);
    gpt_time_in = 16'h0002;
    for (i = 0; i < 3; i++)
    begin
      gpt_trig_in = i[1:0];
      active_p2p_in = (i == 2);
      strobe(i == 2 ? 4 : i + 1);
      wt(4);
      chk(gpt_run_out, 1'h1);
      wt(24);
      chk(gpt_irq_flag_out, 1'h1);
      hs(6);
    end
    {gpt_trig_in, active_p2p_in} = 3'h6;
    hs(3);
    wt(12);
    hs(3);
    wt(12);
    chk(gpt_irq_flag_out, 1'h0);
    wt(12);
    chk(gpt_irq_flag_out, 1'h1);
    hs(6);
    hs(3);
    wt(4);
    hs(0);
    wt(3);
    chk(gpt_run_out, 1'h0);
    nrt_uncond_in = 1'h1;
    hs(2);
    wt(4);
    hs(0);
    wt(3);
    chk(nrt_run_out, 1'h1);
    wt(80);
    chk(nre_irq_flag_out, 1'h1);
    hs(5);
    {osc_ok_in, wake_mode_in, wake_time_in} = 10'h101;
    hs(3);
    hs(4);
    wt(4);
    chk(gpt_run_out, 1'h0);
    chk(wake_run_out, 1'h0);
    wake_mode_in = 1'h0;
    hs(4);
    wt(4);
    chk(rc_osc_en_out, 1'h1);
    hs(0);
    wt(2);
    chk(wake_run_out, 1'h1);
    wt(140);
    chk(wake_timer_irq_flag_out, 1'h1);
    hs(7);
    {osc_ok_in, lp_target_in} = 2'h3;
    hs(1);
    wt(500);
    chk(mask_run_out, 1'h1);
    wt(30);
    chk(mask_run_out, 1'h0);
    chk(rx_monitor_out, 1'h1);
    // Clock enable low freezes a running timer
    hs(3);
    wt(1);
    ce_in = 1'h0;
    wt(40);
    chk(gpt_run_out, 1'h1);
    chk(gpt_irq_flag_out, 1'h0);
    ce_in = 1'h1;
    wt(24);
    chk(gpt_irq_flag_out, 1'h1);
    // Reset after the general timer expired, then a request right after release
    rst_n_in = 1'h0;
    wt(2);
    chk(gpt_irq_flag_out, 1'h0);
    chk(rx_on_out, 1'h1);
    chk(rx_monitor_out, 1'h0);
    rst_n_in = 1'h1;
    hs(3);
    wt(3);
    chk(gpt_run_out, 1'h1);
    results;
  end
endmodule
`default_nettype wire
